// ---- include/mdc_defs.vh ----
/*
  Constants of the multiply/divide coprocessor: command codes of the core port,
  mode field layout, operation and output codes, register offsets and timing.
  Assumes it is included by bare name from every design file that needs it.
*/
`ifndef MDC_DEFS_VH
`define MDC_DEFS_VH

// ==========================================================================
// Core command codes
`define MDC_CMD_MODE 2'h0
`define MDC_CMD_LOAD 2'h1
`define MDC_CMD_OPER 2'h2

// ==========================================================================
// Mode field layout
`define MDC_MODE_W 7
`define MDC_MODE_RST 7'h00
`define MDC_OUT_HI 6
`define MDC_OUT_LO 4
`define MDC_OP_HI 3
`define MDC_OP_LO 0

// ==========================================================================
// Operation codes
`define MDC_OP_INIT0 4'h0
`define MDC_OP_INIT1 4'h1
`define MDC_OP_INIT2 4'h2
`define MDC_OP_READ 4'h3
`define MDC_OP_UMUL 4'h4
`define MDC_OP_SMUL 4'h5
`define MDC_OP_UDIV 4'h8
`define MDC_OP_SDIV 4'h9
`define MDC_OP_INIT3 4'hA

// ==========================================================================
// Output codes
`define MDC_OUT_R0LO 3'h0
`define MDC_OUT_R0HI 3'h1
`define MDC_OUT_R1LO 3'h2
`define MDC_OUT_R1HI 3'h3

// ==========================================================================
// APB register offsets and fields
`define MDC_ADDR_W 8
`define MDC_REG_MODE 8'h00
`define MDC_REG_RESULT_REG_ZERO 8'h04
`define MDC_REG_RESULT_REG_ONE 8'h08
`define MDC_REG_STAT 8'h0C
`define MDC_STAT_BUSY 0

// ==========================================================================
// Timing
`define MDC_DIV_STEPS 5'h10
`define MDC_FLAGS_CLR 4'h0

`endif

// ---- src/mdc_divider.v ----
/*
  Iterative 32/32 divider, two quotient bits per cycle, signed or unsigned.
  Assumes start is a one-cycle pulse with operands valid in that cycle.
*/
`timescale 1ns/100ps
`include "mdc_defs.vh"

module mdc_divider (
  input wire mclk,
  input wire nrst,
  input wire start,
  input wire signedOp,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  output reg done,
  output reg [31:0] quotient,
  output reg [31:0] remainder
);

  // ==========================================================================
  // One restoring step: shift in one dividend bit, subtract when it fits.
  function [64:0] divStep;
    input [32:0] remIn;
    input [31:0] quoIn;
    input [31:0] dvs;
    reg [32:0] sh;
    begin
      sh = {remIn[31:0], quoIn[31]};
      if (sh >= {1'b0, dvs})
      begin
        divStep = {sh - {1'b0, dvs}, quoIn[30:0], 1'b1};
      end
      else
      begin
        divStep = {sh, quoIn[30:0], 1'b0};
      end
    end
  endfunction

  reg [32:0] rem_q;
  reg [31:0] quo_q;
  reg [31:0] dvs_q;
  reg [4:0] cnt_q;
  reg busy_q;
  reg fix_q;
  reg negQ_q;
  reg negR_q;
  wire negA;
  wire negB;
  wire [31:0] absA;
  wire [31:0] absB;
  wire [64:0] stepOne;
  wire [64:0] stepTwo;

  assign negA = signedOp & dividend[31];
  assign negB = signedOp & divisor[31];
  assign absA = negA ? (~dividend + 32'h00000001) : dividend;
  assign absB = negB ? (~divisor + 32'h00000001) : divisor;
  assign stepOne = divStep(rem_q, quo_q, dvs_q);
  assign stepTwo = divStep(stepOne[64:32], stepOne[31:0], dvs_q);

  // ==========================================================================
  // Sixteen double steps, then one sign fix cycle.
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rem_q <= 33'h000000000;
      quo_q <= 32'h00000000;
      dvs_q <= 32'h00000000;
      cnt_q <= 5'h00;
      busy_q <= 1'b0;
      fix_q <= 1'b0;
      negQ_q <= 1'b0;
      negR_q <= 1'b0;
      done <= 1'b0;
      quotient <= 32'h00000000;
      remainder <= 32'h00000000;
    end
    else
    begin
      done <= 1'b0;
      fix_q <= 1'b0;
      if (start)
      begin
        rem_q <= 33'h000000000;
        quo_q <= absA;
        dvs_q <= absB;
        cnt_q <= `MDC_DIV_STEPS;
        busy_q <= 1'b1;
        negQ_q <= negA ^ negB;
        negR_q <= negA;
      end
      else if (busy_q)
      begin
        rem_q <= stepTwo[64:32];
        quo_q <= stepTwo[31:0];
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01)
        begin
          busy_q <= 1'b0;
          fix_q <= 1'b1;
        end
      end
      if (fix_q)
      begin
        quotient <= negQ_q ? (~quo_q + 32'h00000001) : quo_q;
        remainder <= negR_q ? (~rem_q[31:0] + 32'h00000001) : rem_q[31:0];
        done <= 1'b1;
      end
    end
  end

endmodule // mdc_divider

// ---- src/mdc_top.v ----
/*
  Multiply/divide coprocessor: core instruction port, result registers,
  single-cycle multiplier, iterative divider and an APB register slave.
  Assumes the core issues one command at a time and holds it while cpReady is low.
*/
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "mdc_defs.vh"

module mdc_top (
  input wire mclk,
  input wire nrst,
  input wire cpValid,
  input wire [1:0] cpCmd,
  input wire [15:0] cpRd,
  input wire [15:0] cpRs,
  output wire cpReady,
  output reg cpDone,
  output reg [15:0] cpResult,
  output reg [3:0] cpFlags,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr
);

  // ==========================================================================
  // State.
  reg [6:0] mode_q;
  reg [6:0] mode_d;
  reg [31:0] result_reg_zero_q;
  reg [31:0] result_reg_zero_d;
  reg [31:0] result_reg_one_q;
  reg [31:0] result_reg_one_d;
  reg divBusy_q;
  reg divBusy_d;
  reg ansDone_d;
  reg [15:0] ansResult_d;
  reg [3:0] ansFlags_d;
  reg [31:0] rdData_d;

  wire [3:0] opField;
  wire [2:0] outSel;
  wire taken;
  wire isMode;
  wire isLoad;
  wire isOper;
  wire isMul;
  wire isDiv;
  wire signedMul;
  wire [31:0] mulA;
  wire [31:0] mulB;
  wire [63:0] mulFull;
  wire [31:0] product;
  wire [31:0] divisorWord;
  wire divStart;
  wire divDone;
  wire [31:0] divQuo;
  wire [31:0] divRem;

  assign opField = mode_q[`MDC_OP_HI:`MDC_OP_LO];
  assign outSel = mode_q[`MDC_OUT_HI:`MDC_OUT_LO];

  // ==========================================================================
  // Core command decode; a division in flight stalls the port.
  assign cpReady = ~divBusy_q;
  assign taken = cpValid & ~divBusy_q;
  assign isMode = taken & (cpCmd == `MDC_CMD_MODE);
  assign isLoad = taken & (cpCmd == `MDC_CMD_LOAD);
  assign isOper = taken & (cpCmd == `MDC_CMD_OPER);
  assign isMul = (opField == `MDC_OP_UMUL) | (opField == `MDC_OP_SMUL);
  assign isDiv = (opField == `MDC_OP_UDIV) | (opField == `MDC_OP_SDIV);

  // ==========================================================================
  // Multiplier, combinational so the product lands at the taking edge.
  assign signedMul = (opField == `MDC_OP_SMUL);
  assign mulA = {{16{signedMul & cpRd[15]}}, cpRd};
  assign mulB = {{16{signedMul & cpRs[15]}}, cpRs};
  assign mulFull = mulA * mulB;
  assign product = mulFull[31:0];

  // ==========================================================================
  // Divider.
  assign divisorWord = {cpRd, cpRs};
  assign divStart = isOper & isDiv;

  mdc_divider u_mdc_divider (
    .mclk(mclk),
    .nrst(nrst),
    .start(divStart),
    .signedOp(opField == `MDC_OP_SDIV),
    .dividend(result_reg_zero_q),
    .divisor(divisorWord),
    .done(divDone),
    .quotient(divQuo),
    .remainder(divRem)
  );

  // ==========================================================================
  // Output half selection.
  function [15:0] pickHalf;
    input [2:0] sel;
    input [31:0] r0;
    input [31:0] r1;
    begin
      case (sel)
        `MDC_OUT_R0LO: pickHalf = r0[15:0];
        `MDC_OUT_R0HI: pickHalf = r0[31:16];
        `MDC_OUT_R1LO: pickHalf = r1[15:0];
        `MDC_OUT_R1HI: pickHalf = r1[31:16];
        default: pickHalf = 16'h0000;
      endcase
    end
  endfunction

  // ==========================================================================
  // APB decode.
  wire apbAccess;
  wire apbWrite;
  wire apbMapped;
  wire apbModeWr;
  wire apbRefuse;

  assign apbAccess = psel & penable;
  assign apbMapped = (paddr == `MDC_REG_MODE) | (paddr == `MDC_REG_RESULT_REG_ZERO) |
                     (paddr == `MDC_REG_RESULT_REG_ONE) | (paddr == `MDC_REG_STAT);
  assign apbModeWr = pwrite & (paddr == `MDC_REG_MODE);
  assign apbRefuse = ~apbMapped | (pwrite & (paddr != `MDC_REG_MODE)) |
                     (apbModeWr & (divBusy_q | taken));
  assign apbWrite = apbAccess & apbModeWr & ~apbRefuse;
  assign pready = 1'b1;
  assign pslverr = apbAccess & apbRefuse;

  // ==========================================================================
  // Mode register.
  always @*
  begin
    mode_d = mode_q;
    if (isMode)
    begin
      mode_d = cpRs[`MDC_MODE_W-1:0];
    end
    else if (apbWrite)
    begin
      mode_d = pwdata[`MDC_MODE_W-1:0];
    end
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= `MDC_MODE_RST;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================================
  // Result registers, written by a load, a multiply, a division end or an INIT0 mode write; otherwise they hold.
  always @*
  begin
    result_reg_zero_d = result_reg_zero_q;
    result_reg_one_d = result_reg_one_q;
    if (divDone)
    begin
      result_reg_zero_d = divQuo;
      result_reg_one_d = divRem;
    end
    else if (isMode && (cpRs[`MDC_OP_HI:`MDC_OP_LO] == `MDC_OP_INIT0))
    begin
      result_reg_zero_d = 32'h00000000;
      result_reg_one_d = 32'h00000000;
    end
    else if (apbWrite && (pwdata[`MDC_OP_HI:`MDC_OP_LO] == `MDC_OP_INIT0))
    begin
      result_reg_zero_d = 32'h00000000;
      result_reg_one_d = 32'h00000000;
    end
    else if (isLoad)
    begin
      case (opField)
        `MDC_OP_INIT1: result_reg_zero_d = {16'h0000, cpRs};
        `MDC_OP_INIT2: result_reg_zero_d = {cpRd, cpRs};
        `MDC_OP_INIT3: result_reg_one_d = {cpRd, cpRs};
        default: result_reg_zero_d = result_reg_zero_q;
      endcase
    end
    else if (isOper && isMul)
    begin
      result_reg_zero_d = product;
    end
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      result_reg_zero_q <= 32'h00000000;
      result_reg_one_q <= 32'h00000000;
    end
    else
    begin
      result_reg_zero_q <= result_reg_zero_d;
      result_reg_one_q <= result_reg_one_d;
    end
  end

  // ==========================================================================
  // Division busy flag.
  always @*
  begin
    divBusy_d = divBusy_q;
    if (divStart)
    begin
      divBusy_d = 1'b1;
    end
    else if (divDone)
    begin
      divBusy_d = 1'b0;
    end
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      divBusy_q <= 1'b0;
    end
    else
    begin
      divBusy_q <= divBusy_d;
    end
  end

  // ==========================================================================
  // Answer to the core: result half, flags and a done pulse.
  always @*
  begin
    ansDone_d = 1'b0;
    ansResult_d = cpResult;
    ansFlags_d = cpFlags;
    if (divDone)
    begin
      ansResult_d = pickHalf(outSel, divQuo, divRem);
      ansFlags_d = `MDC_FLAGS_CLR;
      ansDone_d = 1'b1;
    end
    else if (isOper && isMul)
    begin
      ansResult_d = pickHalf(outSel, product, result_reg_one_q);
      ansFlags_d = `MDC_FLAGS_CLR;
      ansDone_d = 1'b1;
    end
    else if (isOper && !isDiv)
    begin
      ansResult_d = pickHalf(outSel, result_reg_zero_q, result_reg_one_q);
      ansFlags_d = `MDC_FLAGS_CLR;
      ansDone_d = 1'b1;
    end
    else if (isMode || isLoad || (taken && !isOper))
    begin
      ansDone_d = 1'b1;
    end
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cpDone <= 1'b0;
      cpResult <= 16'h0000;
      cpFlags <= `MDC_FLAGS_CLR;
    end
    else
    begin
      cpDone <= ansDone_d;
      cpResult <= ansResult_d;
      cpFlags <= ansFlags_d;
    end
  end

  // ==========================================================================
  // APB read data, captured in the setup cycle.
  always @*
  begin
    rdData_d = prdata;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `MDC_REG_MODE: rdData_d = {25'h0000000, mode_q};
        `MDC_REG_RESULT_REG_ZERO: rdData_d = result_reg_zero_q;
        `MDC_REG_RESULT_REG_ONE: rdData_d = result_reg_one_q;
        `MDC_REG_STAT: rdData_d = {31'h00000000, divBusy_q};
        default: rdData_d = 32'h00000000;
      endcase
    end
  end

  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata <= 32'h00000000;
    end
    else
    begin
      prdata <= rdData_d;
    end
  end

endmodule // mdc_top

// ---- verif/mdc_core_model.sv ----
/*
  Model of the CPU core that drives the coprocessor instruction port.
  Assumes one clock; callers use issue and wait for it to return.
*/
`timescale 1ns/100ps

module mdc_core_model (
  input wire mclk,
  input wire cpReady,
  input wire cpDone,
  input wire [15:0] cpResult,
  output reg cpValid,
  output reg [1:0] cpCmd,
  output reg [15:0] cpRd,
  output reg [15:0] cpRs
);
  // ==========================================================================
  // Idle state.
  initial
  begin
    cpValid = 1'b0;
    cpCmd = 2'h3;
    cpRd = 16'h0000;
    cpRs = 16'h0000;
  end

  // ==========================================================================
  // One command, held until taken, then the answer is returned.
  task issue(input [1:0] c, input [15:0] d, input [15:0] s, output [15:0] r,
    output tmo);
    integer n;
    begin
      tmo = 1'b0;
      @(posedge mclk);
      cpValid <= 1'b1;
      cpCmd <= c;
      cpRd <= d;
      cpRs <= s;
      n = 0;
      do
      begin
        @(posedge mclk);
        n = n + 1;
      end
      while (cpReady !== 1'b1 && n < 40);
      if (cpReady !== 1'b1)
        tmo = 1'b1;
      cpValid <= 1'b0;
      cpRd <= ~d;
      cpRs <= ~s;
      n = 0;
      do
      begin
        @(negedge mclk);
        n = n + 1;
      end
      while (cpDone !== 1'b1 && n < 40);
      if (cpDone !== 1'b1)
        tmo = 1'b1;
      r = cpResult;
    end
  endtask
endmodule // mdc_core_model

// ---- verif/mdc_top_properties.sv ----
/*
  Checker of the coprocessor port timing and results.
  Assumes it is bound to mdc_top and sees only its ports.
*/
`timescale 1ns/100ps
`include "mdc_defs.vh"

module mdc_top_properties (
  input wire mclk,
  input wire nrst,
  input wire cpValid,
  input wire [1:0] cpCmd,
  input wire [15:0] cpRd,
  input wire [15:0] cpRs,
  input wire cpReady,
  input wire cpDone,
  input wire [15:0] cpResult,
  input wire [3:0] cpFlags,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Mode tracking and expected product.
  reg [6:0] modeQ;
  wire take = cpValid && cpReady;
  wire oper = take && cpCmd == `MDC_CMD_OPER;
  wire [3:0] op = modeQ[3:0];
  wire isMul = op == `MDC_OP_UMUL || op == `MDC_OP_SMUL;
  wire isDiv = op == `MDC_OP_UDIV || op == `MDC_OP_SDIV;
  wire signed [31:0] sProd = $signed(cpRd) * $signed(cpRs);
  wire [31:0] uProd = cpRd * cpRs;
  wire [31:0] prod = op[0] ? sProd : uProd;
  wire [15:0] mulHalf = modeQ[4] ? prod[31:16] : prod[15:0];
  wire apbMode = psel && penable && pwrite && paddr == `MDC_REG_MODE && !pslverr;
  always @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      modeQ <= `MDC_MODE_RST;
    else if (take && cpCmd == `MDC_CMD_MODE)
      modeQ <= cpRs[6:0];
    else if (apbMode)
      modeQ <= pwdata[6:0];
  end

  // ==========================================================================
  // Properties.
  sequence divBusy;
    (!cpReady && !cpDone) [*8];
  endsequence
  mul_result_a: assert property (oper && isMul && modeQ[6:5] == 2'h0 |=>
    cpDone && cpResult == $past(mulHalf)) else $error("multiply answer wrong");
  quick_answer_a: assert property (take && !(oper && isDiv) |=> cpDone)
    else $error("answer not in one cycle");
  div_latency_a: assert property (oper && isDiv |=> divBusy ##[9:12] cpDone)
    else $error("division latency out of range");
  flags_clear_a: assert property (cpDone |-> cpFlags == `MDC_FLAGS_CLR)
    else $error("flags not cleared");
  result_hold_a: assert property (!cpDone |-> $stable(cpResult))
    else $error("result changed without answer");
  ready_done_a: assert property ($rose(cpReady) |-> cpDone)
    else $error("ready back without answer");
  apb_ready_a: assert property (psel |-> pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable && (paddr[1:0] != 2'h0 ||
    paddr > `MDC_REG_STAT) |-> pslverr) else $error("unmapped access accepted");
  ro_write_a: assert property (psel && penable && pwrite && (paddr == `MDC_REG_RESULT_REG_ZERO ||
    paddr == `MDC_REG_RESULT_REG_ONE) |-> pslverr) else $error("read-only write accepted");
endmodule // mdc_top_properties

bind mdc_top mdc_top_properties u_mdc_top_properties (.mclk, .nrst, .cpValid, .cpCmd,
  .cpRd, .cpRs, .cpReady, .cpDone, .cpResult, .cpFlags, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pslverr);

// ---- verif/mdc_top_tb.sv ----
/*
  Self-checking bench of the coprocessor: core commands and APB accesses.
  Assumes the core model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`include "mdc_defs.vh"

module mdc_top_tb;
  reg mclk = 1'b0;
  reg nrst = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h00000000;
  wire cpValid, cpReady, cpDone, pready, pslverr;
  wire [1:0] cpCmd;
  wire [15:0] cpRd, cpRs, cpResult;
  wire [3:0] cpFlags;
  wire [31:0] prdata;
  integer failures = 0;
  integer nChecks = 0;
  integer i;
  reg [15:0] r;
  reg [31:0] d;
  reg e;
  localparam [127:0] DEXP = 128'h8765_FFFD_0000_FFFF_4321_FFFF_0000_FFFF;
  always #2 mclk = ~mclk;
  mdc_top u_mdc_top (.mclk, .nrst, .cpValid, .cpCmd, .cpRd, .cpRs, .cpReady, .cpDone,
    .cpResult, .cpFlags, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr);
  mdc_core_model u_mdc_core_model (.mclk, .cpReady, .cpDone, .cpResult, .cpValid, .cpCmd,
    .cpRd, .cpRs);

  // ==========================================================================
  // Tasks.
  task check(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      nChecks = nChecks + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cp(input [1:0] c, input [15:0] dd, input [15:0] s);
    reg lost;
    begin
      u_mdc_core_model.issue(c, dd, s, r, lost);
      if (lost !== 1'b0)
        failures = failures + 1;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] wd);
    integer n;
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge mclk);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
        failures = failures + 1;
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d failures %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // ==========================================================================
  // Watchdog.
  initial
  begin
    #40000;
    failures = failures + 1;
    end_sim;
  end

  // ==========================================================================
  // Tests.
  initial
  begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    check("ready", cpReady, 32'h1);
    check("done", cpDone, 32'h0);
    apb(1'b0, `MDC_REG_MODE, 32'h0);
    check("modeRst", d, 32'h0);
    cp(`MDC_CMD_MODE, 16'h0, 16'h0004);
    cp(`MDC_CMD_OPER, 16'hFFFF, 16'hFFFF);
    check("umulLo", r, 32'h0001);
    check("flags", cpFlags, 32'h0);
    cp(`MDC_CMD_MODE, 16'h0, 16'h0013);
    cp(`MDC_CMD_OPER, 16'h0, 16'h0);
    check("umulHi", r, 32'hFFFE);
    apb(1'b0, `MDC_REG_RESULT_REG_ZERO, 32'h0);
    check("result_reg_zero", d, 32'hFFFE0001);
    cp(`MDC_CMD_MODE, 16'h0, 16'h0015);
    cp(`MDC_CMD_OPER, 16'hFFFF, 16'h0002);
    check("smulHi", r, 32'hFFFF);
    // Divisions never use a zero dividend with a zero divisor.
    for (i = 7; i >= 0; i = i - 1)
    begin
      d = i[0] ? 32'hFFFFFFF9 : 32'h87654321;
      cp(`MDC_CMD_MODE, 16'h0, 16'h0002);
      cp(`MDC_CMD_LOAD, d[31:16], d[15:0]);
      cp(`MDC_CMD_MODE, 16'h0, {10'h0, i[2:1], 3'h4, i[0]});
      cp(`MDC_CMD_OPER, {15'h0, !i[0]}, {14'h0, i[0], 1'b0});
      check("div", r, DEXP[127 - 16 * i -: 16]);
      check("divFlags", cpFlags, 32'h0);
    end
    cp(`MDC_CMD_MODE, 16'h0, 16'h0013);
    cp(`MDC_CMD_OPER, 16'h0, 16'h0);
    check("quoHi", r, 32'h0000);
    cp(`MDC_CMD_MODE, 16'h0, 16'h0023);
    cp(`MDC_CMD_OPER, 16'h0, 16'h0);
    check("remLo", r, 32'h4321);
    cp(`MDC_CMD_MODE, 16'h0, 16'h0033);
    cp(`MDC_CMD_OPER, 16'h0, 16'h0);
    check("remHi", r, 32'h0000);
    apb(1'b0, `MDC_REG_RESULT_REG_ONE, 32'h0);
    check("result_reg_one", d, 32'h00004321);
    apb(1'b1, `MDC_REG_RESULT_REG_ZERO, 32'h12345678);
    check("roErr", e, 32'h1);
    apb(1'b0, `MDC_REG_RESULT_REG_ZERO, 32'h0);
    check("res0Keep", d, 32'h00008765);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", e, 32'h1);
    apb(1'b0, `MDC_REG_STAT, 32'h0);
    check("idle", d, 32'h0);
    apb(1'b0, `MDC_REG_MODE, 32'h0);
    check("mode", d, 32'h33);
    apb(1'b1, `MDC_REG_MODE, 32'h04);
    cp(`MDC_CMD_OPER, 16'h0003, 16'h0005);
    check("apbMul", r, 32'h000F);
    cp(`MDC_CMD_MODE, 16'h0, 16'h000A);
    cp(`MDC_CMD_LOAD, 16'h1234, 16'h5678);
    apb(1'b0, `MDC_REG_RESULT_REG_ONE, 32'h0);
    check("load3", d, 32'h12345678);
    cp(`MDC_CMD_MODE, 16'h0, 16'h0001);
    cp(`MDC_CMD_LOAD, 16'hAAAA, 16'h00BB);
    apb(1'b0, `MDC_REG_RESULT_REG_ZERO, 32'h0);
    check("load1", d, 32'h000000BB);
    cp(2'h3, 16'h0, 16'h0);
    cp(`MDC_CMD_MODE, 16'h0, 16'h0000);
    apb(1'b0, `MDC_REG_RESULT_REG_ONE, 32'h0);
    check("clear", d, 32'h0);
    end_sim;
  end
endmodule // mdc_top_tb
